// ---- pfgpio_pkg.sv ----
// Package with register map, reset values and carriers of the port F GPIO block
package pfgpio_pkg;

  localparam int unsigned PFGPIO_WIDTH = 8;
  localparam int unsigned PFGPIO_AW = 2;

  // ==========================================================
  // Register offsets
  localparam logic [1:0] PFGPIO_OFS_DIRECTION = 2'h0;
  localparam logic [1:0] PFGPIO_OFS_OUTPUT_LATCH = 2'h1;
  localparam logic [1:0] PFGPIO_OFS_PIN_READBACK = 2'h2;

  // ==========================================================
  // Reset and fixed read values
  localparam logic [7:0] PFGPIO_RST_DIRECTION = 8'h00;
  localparam logic [7:0] PFGPIO_RST_OUTPUT_LATCH = 8'h00;
  localparam logic [7:0] PFGPIO_DIRECTION_READ = 8'hff;
  localparam logic [7:0] PFGPIO_UNMAPPED_READ = 8'h00;
  localparam logic [7:0] PFGPIO_IDLE_READ = 8'h00;

  // ==========================================================
  // Pin positions
  localparam int unsigned PFGPIO_BIT_INTERRUPT_TWO = 0;
  localparam int unsigned PFGPIO_BIT_TRIGGER = 3;
  localparam int unsigned PFGPIO_BIT_CLOCK = 7;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pfgpio_req_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pfgpio_pins_t;

endpackage : pfgpio_pkg

// ---- pfgpio_top.sv ----
// Port F general purpose I/O port: registers, pin drive and alternate functions
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/100ps
// Overview of operation
// (RULE1) Direction register: eight bits, 1 makes pin output, 0 makes input.
// (RULE2) Direction register is write-only; reads return a fixed meaningless value.
// (RULE3) Direction bit 7 set drives the system clock on pin 7, else input; the code drives a half-rate toggle of i_clk instead.
// (RULE4) Output latch is eight bits, read/write, holds levels driven on output pins.
// (RULE5) Software writes only zero to latch bit 7; it resets to zero.
// (RULE6) Readback register is read-only; writes change nothing.
// (RULE7) Readback bit is latch bit for outputs, sampled pin level for inputs.
// (RULE8) Readback has no reset value; it follows the pin levels.
// (RULE9) Pin 3 is converter trigger input when both trigger select bits are 1.
// (RULE10) Pin 0 also feeds external interrupt two, besides ordinary I/O.
// (RULE11) An interrupt pin should not also be used for another function; pin 3 feeds both interrupt three and the converter trigger.
// (RULE12) Pins 6 to 1 are outputs when direction bit is 1, inputs otherwise.
// (RULE13) Reset clears direction and latch, so all pins start as inputs.
module pfgpio_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [7:0] i_pin_in,
  output logic [7:0] o_pin_out,
  output logic [7:0] o_pin_oe,
  input wire logic i_trigger_source_sel_hi,
  input wire logic i_trigger_source_sel_lo,
  output logic o_converter_trigger_in,
  output logic o_ext_interrupt_two,
  output logic o_ext_interrupt_three
);

  // ==========================================================
  // Register state
  pfgpio_pkg::pfgpio_req_t req;
  logic [7:0] port_f_direction;
  logic [7:0] port_f_output_latch;
  logic [7:0] next_port_f_direction;
  logic [7:0] next_port_f_output_latch;
  logic [7:0] pin_sample;
  logic [7:0] port_f_pin_readback;
  logic [7:0] next_rdata;

  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  always_comb begin
    next_port_f_direction = port_f_direction;
    next_port_f_output_latch = port_f_output_latch;
    if (req.wr) begin
      case (req.addr)
        pfgpio_pkg::PFGPIO_OFS_DIRECTION: begin
          next_port_f_direction = req.wdata; // RULE1
        end
        pfgpio_pkg::PFGPIO_OFS_OUTPUT_LATCH: begin
          // Bit 7 kept as written; software is expected to leave it zero
          next_port_f_output_latch = req.wdata; // RULE4 RULE5
        end
        default: begin
          // Readback and unmapped offsets swallow writes
          next_port_f_direction = port_f_direction; // RULE6
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      port_f_direction <= pfgpio_pkg::PFGPIO_RST_DIRECTION; // RULE13
      port_f_output_latch <= pfgpio_pkg::PFGPIO_RST_OUTPUT_LATCH; // RULE13 RULE5
    end else begin
      port_f_direction <= next_port_f_direction;
      port_f_output_latch <= next_port_f_output_latch;
    end
  end

  // ==========================================================
  // Pin sampling, deliberately unreset so readback follows the pins
  always_ff @(posedge i_clk) begin
    pin_sample <= i_pin_in; // RULE8
  end

  genvar gi;
  generate
    for (gi = 0; gi < pfgpio_pkg::PFGPIO_WIDTH; gi++) begin : g_readback
      assign port_f_pin_readback[gi] = port_f_direction[gi] ? port_f_output_latch[gi] : pin_sample[gi]; // RULE7
    end
  endgenerate

  // ==========================================================
  // Read port: data stands only in the cycle after the strobe
  always_comb begin
    next_rdata = pfgpio_pkg::PFGPIO_IDLE_READ;
    if (req.rd) begin
      case (req.addr)
        pfgpio_pkg::PFGPIO_OFS_DIRECTION: next_rdata = pfgpio_pkg::PFGPIO_DIRECTION_READ; // RULE2
        pfgpio_pkg::PFGPIO_OFS_OUTPUT_LATCH: next_rdata = port_f_output_latch; // RULE4
        pfgpio_pkg::PFGPIO_OFS_PIN_READBACK: next_rdata = port_f_pin_readback; // RULE7
        default: next_rdata = pfgpio_pkg::PFGPIO_UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= pfgpio_pkg::PFGPIO_IDLE_READ;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  // ==========================================================
  // Pin drive
  pfgpio_pkg::pfgpio_pins_t pins;
  pfgpio_pkg::pfgpio_pins_t next_pins;
  logic clock_phase;
  logic next_clock_phase;
  logic trigger_mode;

  assign trigger_mode = i_trigger_source_sel_hi & i_trigger_source_sel_lo;

  always_comb begin
    // Clock copy is a half-rate toggle; a flop cannot carry the full-rate clock
    next_clock_phase = ~clock_phase;
    next_pins.out = port_f_output_latch; // RULE12
    next_pins.oe = port_f_direction; // RULE12 RULE10
    next_pins.out[pfgpio_pkg::PFGPIO_BIT_CLOCK] = next_clock_phase; // RULE3
    // Trigger mode overrides the direction bit so the pin never fights the trigger
    if (trigger_mode) begin
      next_pins.oe[pfgpio_pkg::PFGPIO_BIT_TRIGGER] = 1'b0; // RULE9
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      clock_phase <= 1'b0;
      pins <= '0; // RULE13
    end else begin
      clock_phase <= next_clock_phase;
      pins <= next_pins;
    end
  end

  assign o_pin_out = pins.out;
  assign o_pin_oe = pins.oe;

  // ==========================================================
  // Alternate inputs, taken from the sampled pin levels
  logic next_trigger;

  assign next_trigger = trigger_mode & pin_sample[pfgpio_pkg::PFGPIO_BIT_TRIGGER];

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_converter_trigger_in <= 1'b0;
      o_ext_interrupt_two <= 1'b0;
      o_ext_interrupt_three <= 1'b0;
    end else begin
      o_converter_trigger_in <= next_trigger; // RULE9
      o_ext_interrupt_two <= pin_sample[pfgpio_pkg::PFGPIO_BIT_INTERRUPT_TWO]; // RULE10
      o_ext_interrupt_three <= pin_sample[pfgpio_pkg::PFGPIO_BIT_TRIGGER];
    end
  end

endmodule : pfgpio_top

// ---- pfgpio_props.sv ----
// Checker of the port F GPIO port
`timescale 1ns/100ps
module pfgpio_props (
  input wire logic i_clk, i_rst, i_wr, i_rd,
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata, i_pin_in, o_rdata, o_pin_out, o_pin_oe,
  input wire logic i_trigger_source_sel_hi, i_trigger_source_sel_lo, o_ext_interrupt_two, o_ext_interrupt_three
);
  wire logic trg = i_trigger_source_sel_hi & i_trigger_source_sel_lo;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Pins trail the write edge by one more stage
  sequence s_wr(logic [1:0] a);
    i_wr && i_addr == a ##2 1'b1;
  endsequence
  a_dir_read: assert property (i_rd && i_addr == 2'h0 |=> o_rdata == 8'hff)
    else $error("bad dir read");
  a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("rdata not idle");
  a_reset_clear: assert property (disable iff (1'b0) i_rst |=> o_pin_oe == 8'h00 && o_pin_out == 8'h00)
    else $error("reset not clean");
  a_clock_out: assert property (!$past(i_rst) |-> o_pin_out[7] != $past(o_pin_out[7]))
    else $error("clock out stuck");
  a_latch_pins: assert property (s_wr(2'h1) |-> o_pin_out[6:0] == $past(i_wdata[6:0], 2))
    else $error("latch not on pins");
  a_dir_oe: assert property (s_wr(2'h0) |-> (o_pin_oe & 8'hf7) == ($past(i_wdata, 2) & 8'hf7))
    else $error("dir not on enables");
  a_trig_oe: assert property (trg |=> !o_pin_oe[3])
    else $error("trigger pin driven");
  a_irq_pins: assert property (!$past(i_rst) |-> {o_ext_interrupt_three, o_ext_interrupt_two} ==
    {$past(i_pin_in[3], 2), $past(i_pin_in[0], 2)}) else $error("irq not following pin");
endmodule : pfgpio_props
bind pfgpio_top pfgpio_props u_props (.*);

// ---- pfgpio_board.sv ----
// Board circuitry on the port F pins
`timescale 1ns/100ps
module pfgpio_board (input wire logic [7:0] i_out, i_oe, i_ext, output logic [7:0] o_pin);
  // Drives released pins only, no second use of them
  assign o_pin = (i_oe & i_out) | (~i_oe & i_ext);
endmodule : pfgpio_board

// ---- tb_pfgpio_top.sv ----
// Self-checking bench of the port F GPIO port
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
$display("unexpected %0t %h %h", $time, a, b); end end
module tb_pfgpio_top;
  logic i_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0;
  logic [1:0] i_addr = 0, sel = 0;
  logic [7:0] i_wdata = 0, ext = 8'h3c, d, l, o_rdata, o_pin_out, o_pin_oe, i_pin_in;
  wire logic i_trigger_source_sel_hi = sel[1], i_trigger_source_sel_lo = sel[0];
  logic o_converter_trigger_in, o_ext_interrupt_two, o_ext_interrupt_three;
  int num_errors = 0, checks_done = 0;
  // Direction, latch, board level, trigger selects
  logic [25:0] rows [4] = '{{8'h00,8'h00,8'ha5,2'h0}, {8'hff,8'h7e,8'h00,2'h1},
    {8'h0f,8'h55,8'hc3,2'h2}, {8'h88,8'h08,8'h77,2'h3}};
  pfgpio_top u_dut (.*);
  pfgpio_board u_board (.i_out(o_pin_out), .i_oe(o_pin_oe), .i_ext(ext), .o_pin(i_pin_in));
  initial forever #2 i_clk = ~i_clk;
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge i_clk);
    {i_wr, i_addr, i_wdata} <= {1'b1, a, v};
    @(posedge i_clk);
    i_wr <= 0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] v);
    @(posedge i_clk);
    {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_clk);
    i_rd <= 0;
    #1 `CHK(o_rdata, v)
  endtask : rd
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  initial begin
    repeat (5) @(posedge i_clk);
    i_rst <= 0;
    rd(1, 8'h00);
    `CHK(o_pin_oe, 8'h00)
    rd(2, 8'h3c);
    rd(0, 8'hff);
    rd(3, 8'h00);
    $display("reset test end");
    foreach (rows[i]) begin
      @(posedge i_clk);
      {d, l} = rows[i][25:10];
      {ext, sel} <= rows[i][9:0];
      wr(0, d);
      wr(1, l);
      repeat (2) @(posedge i_clk);
      #1 `CHK(o_pin_oe, d & (sel == 2'h3 ? 8'hf7 : 8'hff))
      `CHK(o_pin_out[6:0], l[6:0])
      rd(2, (d & l) | (~d & ext));
      rd(1, l);
    end
    $display("table test end");
    wr(2, 8'hff);
    wr(3, 8'hff);
    rd(2, 8'h7f);
    rd(1, 8'h08);
    $display("read-only test end");
    @(posedge i_clk);
    ext <= 8'h0e;
    repeat (4) @(posedge i_clk);
    // Look after the edge so the registered outputs have settled
    #1 `CHK(o_converter_trigger_in, 1'b1)
    `CHK(o_ext_interrupt_three, 1'b1)
    `CHK(o_ext_interrupt_two, 1'b0)
    $display("alternate test end");
    @(posedge i_clk);
    i_rst <= 1;
    repeat (5) @(posedge i_clk);
    i_rst <= 0;
    #1 `CHK(o_pin_oe, 8'h00)
    rd(1, 8'h00);
    @(posedge i_clk);
    sel <= 2'h0;
    repeat (3) @(posedge i_clk);
    #1 `CHK(o_converter_trigger_in, 1'b0)
    `CHK(o_ext_interrupt_three, 1'b1)
    $display("second reset test end");
    close_out();
  end
  initial begin
    #40000;
    num_errors++;
    close_out();
  end
endmodule : tb_pfgpio_top
